// [lhi_pkg.sv]
// constants and types for the display driver host interface
package lhi_pkg;
    // synchroniser vector layout (pins from the host)
    localparam int LHI_SYNC_W = 23;
    localparam int LHI_S_CS1  = 0;
    localparam int LHI_S_CS2  = 1;
    localparam int LHI_S_RS   = 2;
    localparam int LHI_S_RD   = 3;
    localparam int LHI_S_WR   = 4;
    localparam int LHI_S_PSX  = 5;
    localparam int LHI_S_C86  = 6;
    localparam int LHI_S_DLO  = 7;
    localparam int LHI_S_DHI  = 22;

    // internal register file
    localparam int          LHI_REG_N    = 16;
    localparam logic [7:0]  LHI_REG_LIM  = 8'h10;
    localparam logic [7:0]  LHI_IDX_DACR = 8'h05;
    localparam logic [7:0]  LHI_IDX_DMEM = 8'h0c;
    localparam logic [7:0]  LHI_REG_RST  = 8'h00;
    localparam logic [7:0]  LHI_IDX_RST  = 8'h00;
    localparam int          LHI_BWF_BIT  = 7;
    localparam int          LHI_HS_BIT   = 0;

    // pixel word layout, most significant dot first
    localparam int LHI_DOT1_HI = 15;
    localparam int LHI_DOT1_LO = 11;
    localparam int LHI_DOT2_HI = 10;
    localparam int LHI_DOT2_LO = 6;
    localparam int LHI_DOT3_HI = 5;
    localparam int LHI_DOT3_LO = 0;

    // high-speed buffer holds three words, the fourth arrives live
    localparam int          LHI_HS_HELD  = 3;
    localparam logic [1:0]  LHI_HS_LAST  = 2'h3;
    localparam logic [2:0]  LHI_SER_LAST = 3'h7;

    typedef enum logic [1:0] {
        LHI_PK_HI = 2'b00,
        LHI_PK_LO = 2'b01
    } lhi_pack_t;
endpackage

// [lhi_host_if.sv]
// host bus interface of the display source driver
`timescale 1ns/1ns
module lhi_host_if
    import lhi_pkg::*;
(
    // core clock and reset
    input  wire logic         core_clk_in,
    input  wire logic         sys_rst_in,
    // serial link
    input  wire logic         serial_clk_in,
    input  wire logic         serial_data_in,
    // mode straps
    input  wire logic         interface_kind_select_in,
    input  wire logic         cpu_family_select_in,
    // parallel host pins
    input  wire logic         cs1_n_in,
    input  wire logic         cs2_n_in,
    input  wire logic         register_select_in,
    input  wire logic         rd_e_in,
    input  wire logic         wr_rw_in,
    input  wire logic [15:0]  data_in,
    output logic      [15:0]  data_out,
    output logic      [15:0]  data_oe_n_out,
    // display side
    output logic      [15:0]  pixel_word_out,
    output logic              pixel_valid_out,
    output logic      [4:0]   dot1_out,
    output logic      [4:0]   dot2_out,
    output logic      [5:0]   dot3_out,
    output logic      [63:0]  burst_out,
    output logic              burst_valid_out,
    // command side
    output logic      [7:0]   index_out,
    output logic      [7:0]   cmd_data_out,
    output logic              cmd_valid_out,
    output logic              bus_width_flag_out,
    output logic              high_speed_mode_out
);
    import lhi_pkg::*;

    // core domain state
    logic [LHI_SYNC_W-1:0] s1_reg, s2_reg, s3_reg, filt_reg, prev_reg;
    logic [LHI_SYNC_W-1:0] s1_next, s2_next, s3_next, filt_next;
    logic                  srst_reg;
    logic                  ts1_reg, ts2_reg, ts3_reg, tseen_reg;
    logic                  ts1_next, ts2_next, ts3_next, tseen_next;
    logic [7:0]            idx_reg, idx_next;
    logic [7:0]            regs_reg [LHI_REG_N];
    logic [7:0]            regs_next [LHI_REG_N];
    lhi_pack_t             pk_reg, pk_next;
    logic [7:0]            hi_reg, hi_next;
    logic [15:0]           hbuf_reg [LHI_HS_HELD];
    logic [15:0]           hbuf_next [LHI_HS_HELD];
    logic [1:0]            hcnt_reg, hcnt_next;
    logic                  dirty_reg, dirty_next;
    logic [15:0]           pix_reg, pix_next;
    logic                  pv_reg, pv_next;
    logic [63:0]           burst_reg, burst_next;
    logic                  bv_reg, bv_next;
    logic [7:0]            cd_reg, cd_next;
    logic                  cv_reg, cv_next;
    logic [15:0]           dout_reg, dout_next;
    logic [15:0]           oe_reg, oe_next;
    logic [4:0]            d1_reg, d1_next, d2_reg, d2_next;
    logic [5:0]            d3_reg, d3_next;

    // serial domain state
    logic [6:0]            sh_reg, sh_next;
    logic [2:0]            cnt_reg, cnt_next;
    logic [7:0]            sb_reg, sb_next;
    logic                  srs_reg, srs_next, tog_reg, tog_next;
    logic                  ser_arst;

    // decoded core signals
    logic                  sel, sel_prev, interface_kind_select, c86, rs, bwf, hs;
    logic                  par_wr, ser_ev, ev, ev_rs, ev_wide, rd_act;
    logic [15:0]           ev_word;
    logic [7:0]            ev_byte, rbyte;

    // ---------------- serial link domain ----------------
    // raw pins as async clear: a glitch on select only drops a byte early
    assign ser_arst = cs1_n_in | cs2_n_in | interface_kind_select_in
                    | srst_reg;

    always_comb begin
        sh_next  = {sh_reg[5:0], serial_data_in};
        cnt_next = cnt_reg + 3'h1;
        sb_next  = sb_reg;
        srs_next = srs_reg;
        tog_next = tog_reg;
        if (cnt_reg == LHI_SER_LAST) begin
            sb_next  = {sh_reg, serial_data_in};
            srs_next = register_select_in;
            tog_next = ~tog_reg;
        end
    end

    always_ff @(posedge serial_clk_in or posedge ser_arst) begin
        if (ser_arst) begin
            sh_reg  <= 7'h00;
            cnt_reg <= 3'h0;
        end else begin
            sh_reg  <= sh_next;
            cnt_reg <= cnt_next;
        end
    end

    // byte and toggle survive deselect so the core can still pick them up
    always_ff @(posedge serial_clk_in or posedge srst_reg) begin
        if (srst_reg) begin
            sb_reg  <= 8'h00;
            srs_reg <= 1'b0;
            tog_reg <= 1'b0;
        end else begin
            sb_reg  <= sb_next;
            srs_reg <= srs_next;
            tog_reg <= tog_next;
        end
    end

    ser_byte_a: assert property (@(posedge serial_clk_in)
        disable iff (ser_arst)
        (cnt_reg == LHI_SER_LAST) |=>
            sb_reg == {$past(sh_reg), $past(serial_data_in)})
        else $error("serial byte not taken on eighth edge");

    ser_rs_a: assert property (@(posedge serial_clk_in)
        disable iff (ser_arst)
        (cnt_reg == LHI_SER_LAST) |=>
            srs_reg == $past(register_select_in) && tog_reg != $past(tog_reg))
        else $error("serial select not sampled on eighth edge");

    // ---------------- core domain ----------------
    assign sel      = ~filt_reg[LHI_S_CS1] & ~filt_reg[LHI_S_CS2];
    assign sel_prev = ~prev_reg[LHI_S_CS1] & ~prev_reg[LHI_S_CS2];
    assign interface_kind_select      = filt_reg[LHI_S_PSX];
    assign c86      = filt_reg[LHI_S_C86];
    assign rs       = filt_reg[LHI_S_RS];
    assign bwf      = regs_reg[LHI_IDX_DACR[3:0]][LHI_BWF_BIT];
    assign hs       = regs_reg[LHI_IDX_DACR[3:0]][LHI_HS_BIT];

    // strobes count only while selected, so deselect masks them
    assign par_wr = sel & interface_kind_select & (c86 ?
        (prev_reg[LHI_S_RD] & ~filt_reg[LHI_S_RD] & ~filt_reg[LHI_S_WR]) :
        (filt_reg[LHI_S_WR] & ~prev_reg[LHI_S_WR]));
    assign ser_ev  = ~interface_kind_select & (ts2_reg == ts3_reg) & (ts3_reg != tseen_reg);
    assign ev      = par_wr | ser_ev;
    assign ev_rs   = par_wr ? rs : srs_reg;
    assign ev_word = par_wr ? filt_reg[LHI_S_DHI:LHI_S_DLO] : {8'h00, sb_reg};
    assign ev_byte = ev_word[7:0];
    assign ev_wide = par_wr & ~bwf;

    // read needs select high; a read with select low is never driven
    assign rd_act = sel & interface_kind_select & rs & (c86 ?
        (filt_reg[LHI_S_RD] & filt_reg[LHI_S_WR]) :
        ~filt_reg[LHI_S_RD]);
    assign rbyte = (idx_reg < LHI_REG_LIM && idx_reg != LHI_IDX_DMEM) ?
        regs_reg[idx_reg[3:0]] : 8'h00;

    always_comb begin
        logic        word_done;
        logic [15:0] word;
        word_done = 1'b0;
        word      = 16'h0000;
        s1_next   = {data_in, cpu_family_select_in, interface_kind_select_in,
                     wr_rw_in, rd_e_in, register_select_in, cs2_n_in,
                     cs1_n_in};
        s2_next   = s1_reg;
        s3_next   = s2_reg;
        // a change counts once the last two stages agree
        filt_next = ((s2_reg ~^ s3_reg) & s3_reg)
                  | ((s2_reg ^ s3_reg) & filt_reg);
        ts1_next   = tog_reg;
        ts2_next   = ts1_reg;
        ts3_next   = ts2_reg;
        tseen_next = (ts2_reg == ts3_reg) ? ts3_reg : tseen_reg;
        idx_next   = idx_reg;
        regs_next  = regs_reg;
        pk_next    = pk_reg;
        hi_next    = hi_reg;
        hbuf_next  = hbuf_reg;
        hcnt_next  = hcnt_reg;
        dirty_next = dirty_reg;
        pix_next   = pix_reg;
        pv_next    = 1'b0;
        burst_next = burst_reg;
        bv_next    = 1'b0;
        cd_next    = cd_reg;
        cv_next    = 1'b0;
        d1_next    = d1_reg;
        d2_next    = d2_reg;
        d3_next    = d3_reg;

        if (ev && !ev_rs) begin
            idx_next = ev_byte;
            pk_next  = LHI_PK_HI;
            if (ev_byte == LHI_IDX_DMEM && dirty_reg) begin
                hcnt_next  = 2'h0;
                dirty_next = 1'b0;
            end
        end else if (ev && idx_reg == LHI_IDX_DMEM) begin
            if (ev_wide) begin
                word_done = 1'b1;
                word      = ev_word;
            end else if (pk_reg == LHI_PK_HI) begin
                hi_next = ev_byte;
                pk_next = LHI_PK_LO;
            end else begin
                word_done = 1'b1;
                word      = {hi_reg, ev_byte};
                pk_next   = LHI_PK_HI;
            end
        end else if (ev) begin
            if (idx_reg < LHI_REG_LIM) begin
                regs_next[idx_reg[3:0]] = ev_byte;
            end
            cd_next = ev_byte;
            cv_next = 1'b1;
        end
        // set wins over a clear in the same cycle
        if (sel_prev && !sel && hcnt_reg != 2'h0) begin
            dirty_next = 1'b1;
        end

        if (word_done) begin
            pix_next = word;
            d1_next  = word[LHI_DOT1_HI:LHI_DOT1_LO];
            d2_next  = word[LHI_DOT2_HI:LHI_DOT2_LO];
            d3_next  = word[LHI_DOT3_HI:LHI_DOT3_LO];
            if (!hs) begin
                pv_next = 1'b1;
            end else if (hcnt_reg == LHI_HS_LAST) begin
                // commit is one cycle, so the next word is never refused
                burst_next = {hbuf_reg[0], hbuf_reg[1], hbuf_reg[2], word};
                bv_next    = 1'b1;
                hcnt_next  = 2'h0;
            end else begin
                hbuf_next[hcnt_reg] = word;
                hcnt_next = hcnt_reg + 2'h1;
            end
        end

        dout_next = {8'h00, rbyte};
        oe_next   = 16'hffff;
        if (rd_act) begin
            oe_next[7:0] = 8'h00;
            if (!bwf) begin
                oe_next[15:8] = 8'h00;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        srst_reg <= sys_rst_in;
        if (sys_rst_in) begin
            // idle level of selects and strobes, so no false edge follows
            s1_reg    <= '1;
            s2_reg    <= '1;
            s3_reg    <= '1;
            filt_reg  <= '1;
            prev_reg  <= '1;
            ts1_reg   <= 1'b0;
            ts2_reg   <= 1'b0;
            ts3_reg   <= 1'b0;
            tseen_reg <= 1'b0;
            idx_reg   <= LHI_IDX_RST;
            for (int i = 0; i < LHI_REG_N; i++) begin
                regs_reg[i] <= LHI_REG_RST;
            end
            pk_reg    <= LHI_PK_HI;
            hi_reg    <= 8'h00;
            for (int i = 0; i < LHI_HS_HELD; i++) begin
                hbuf_reg[i] <= 16'h0000;
            end
            hcnt_reg  <= 2'h0;
            dirty_reg <= 1'b0;
            pix_reg   <= 16'h0000;
            pv_reg    <= 1'b0;
            burst_reg <= 64'h0;
            bv_reg    <= 1'b0;
            cd_reg    <= 8'h00;
            cv_reg    <= 1'b0;
            dout_reg  <= 16'h0000;
            oe_reg    <= 16'hffff;
            d1_reg    <= 5'h00;
            d2_reg    <= 5'h00;
            d3_reg    <= 6'h00;
        end else begin
            s1_reg    <= s1_next;
            s2_reg    <= s2_next;
            s3_reg    <= s3_next;
            filt_reg  <= filt_next;
            prev_reg  <= filt_reg;
            ts1_reg   <= ts1_next;
            ts2_reg   <= ts2_next;
            ts3_reg   <= ts3_next;
            tseen_reg <= tseen_next;
            idx_reg   <= idx_next;
            regs_reg  <= regs_next;
            pk_reg    <= pk_next;
            hi_reg    <= hi_next;
            hbuf_reg  <= hbuf_next;
            hcnt_reg  <= hcnt_next;
            dirty_reg <= dirty_next;
            pix_reg   <= pix_next;
            pv_reg    <= pv_next;
            burst_reg <= burst_next;
            bv_reg    <= bv_next;
            cd_reg    <= cd_next;
            cv_reg    <= cv_next;
            dout_reg  <= dout_next;
            oe_reg    <= oe_next;
            d1_reg    <= d1_next;
            d2_reg    <= d2_next;
            d3_reg    <= d3_next;
        end
    end

    assign data_out            = dout_reg;
    assign data_oe_n_out       = oe_reg;
    assign pixel_word_out      = pix_reg;
    assign pixel_valid_out     = pv_reg;
    assign dot1_out            = d1_reg;
    assign dot2_out            = d2_reg;
    assign dot3_out            = d3_reg;
    assign burst_out           = burst_reg;
    assign burst_valid_out     = bv_reg;
    assign index_out           = idx_reg;
    assign cmd_data_out        = cd_reg;
    assign cmd_valid_out       = cv_reg;
    assign bus_width_flag_out  = bwf;
    assign high_speed_mode_out = hs;

    serial_hiz_a: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        !interface_kind_select |=> data_oe_n_out == 16'hffff)
        else $error("data bus driven in serial mode");

    desel_hiz_a: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        !sel |=> data_oe_n_out == 16'hffff)
        else $error("data bus driven while deselected");

    narrow_upper_a: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        bwf |=> data_oe_n_out[15:8] == 8'hff)
        else $error("upper lines driven on byte bus");

    dmem_read_a: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        (rd_act && idx_reg == LHI_IDX_DMEM) |=>
            data_out == 16'h0000 && data_oe_n_out[7:0] == 8'h00)
        else $error("display register read not zero");

    index_load_a: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        (ev && !ev_rs) |=> index_out == $past(ev_byte))
        else $error("index not loaded");

    byte_pair_a: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        (ev && ev_rs && idx_reg == LHI_IDX_DMEM && !ev_wide &&
         pk_reg == LHI_PK_LO) |=>
            pixel_word_out == {$past(hi_reg), $past(ev_byte)})
        else $error("byte pair assembled wrongly");

    dot_split_a: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        pixel_valid_out |-> dot1_out == pixel_word_out[15:11] &&
            dot3_out == pixel_word_out[5:0])
        else $error("dot fields wrong");

    burst_four_a: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        burst_valid_out |-> $past(hcnt_reg) == LHI_HS_LAST && hcnt_reg == 2'h0)
        else $error("burst not after four words");

    burst_clear_a: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        (ev && !ev_rs && ev_byte == LHI_IDX_DMEM && dirty_reg) |=>
            hcnt_reg == 2'h0 && !dirty_reg)
        else $error("buffer not cleared on reselect");

    cmd_byte_a: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        (ev && ev_rs && idx_reg == LHI_IDX_DACR) |=>
            bus_width_flag_out == $past(ev_byte[7]) && cmd_valid_out)
        else $error("command byte not taken from low lines");
endmodule // lhi_host_if

// [lhi_host_model.sv]
// host cpu model driving the parallel and serial pins of the device
`timescale 1ns/1ns
module lhi_host_model (
    // core clock
    input  wire logic        core_clk_in,
    // device side of the data pins
    input  wire logic [15:0] dev_data_in,
    input  wire logic [15:0] dev_oe_n_in,
    // pins towards the device
    output logic             kind_out,
    output logic             fam_out,
    output logic             cs1_n_out,
    output logic             cs2_n_out,
    output logic             rs_out,
    output logic             rd_e_out,
    output logic             wr_rw_out,
    output logic             sclk_out,
    output logic             sdata_out,
    output logic      [15:0] bus_out
);
    logic [15:0] hd;
    logic [15:0] last;
    logic        hoe;

    initial begin
        {kind_out, fam_out, cs1_n_out, cs2_n_out} = 4'hb;
        {rs_out, rd_e_out, wr_rw_out, sclk_out, sdata_out} = 5'h1c;
        hd = 16'h0000;
        hoe = 1'b0;
        last = 16'h0000;
    end

    // undriven lines show a changing pattern, never the last value
    always @(posedge core_clk_in) last <= bus_out;
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            bus_out[i] = hoe ? hd[i] :
                         (!dev_oe_n_in[i] ? dev_data_in[i] : ~last[i]);
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
        #5;
    endtask

    // straps change only between accesses
    task automatic set_mode(input logic kind, input logic fam);
        tick(1);
        kind_out = kind;
        fam_out = fam;
        rd_e_out = !fam;
        wr_rw_out = 1'b1;
        tick(6);
    endtask

    task automatic select(input logic c1, input logic c2);
        tick(1);
        cs1_n_out = c1;
        cs2_n_out = c2;
        tick(5);
    endtask

    // phases of five cycles keep data stable around the latching edge
    task automatic pwrite(input logic rs, input logic [15:0] d);
        tick(1);
        rs_out = rs;
        hd = d;
        hoe = 1'b1;
        wr_rw_out = 1'b0;
        if (fam_out) rd_e_out = 1'b1;
        tick(5);
        if (fam_out) rd_e_out = 1'b0;
        else wr_rw_out = 1'b1;
        tick(5);
        wr_rw_out = 1'b1;
        hoe = 1'b0;
    endtask

    task automatic pread(input logic rs, output logic [15:0] d,
                         output logic [15:0] on, output logic [15:0] off);
        tick(1);
        rs_out = rs; // select low reads are never issued
        wr_rw_out = 1'b1;
        rd_e_out = fam_out;
        tick(7);
        d = bus_out;
        on = dev_oe_n_in;
        rd_e_out = !fam_out;
        tick(7);
        off = dev_oe_n_in;
    endtask

    // serial clock runs only inside a frame, at 160 ns
    task automatic swrite(input logic rs, input logic [7:0] b, input int nb);
        tick(1);
        rs_out = rs;
        #37;
        for (int i = 7; i > 7 - nb; i--) begin
            sdata_out = b[i];
            #80 sclk_out = 1'b1;
            #80 sclk_out = 1'b0;
        end
        sdata_out = ~sdata_out;
        tick(8);
    endtask
endmodule // lhi_host_model

// [lhi_host_if_tb.sv]
// self-checking bench comparing the host interface with a queue model
`timescale 1ns/1ns
module lhi_host_if_tb;
    import lhi_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, kind, fam, cs1, cs2, rs, rde, wrw;
    logic        sclk, sd, pv, bv, cv, bwf_o, hs_o;
    logic [15:0] bus, dout, oen, pix, d, on, off, pw;
    logic [4:0]  d1, d2;
    logic [5:0]  d3;
    logic [63:0] bst;
    logic [7:0]  idx_o, cd, b, c;
    int          n_errors = 0, n_compared = 0;
    int          bwf, hs, sm, pend, hib, idx, i, dty;
    int          regs [16];
    logic [15:0] bq [$], pq [$], cq [$];
    logic [63:0] brq [$];

    always #50 clk = ~clk;

    lhi_host_model host (.core_clk_in(clk), .dev_data_in(dout),
        .dev_oe_n_in(oen), .kind_out(kind), .fam_out(fam), .cs1_n_out(cs1),
        .cs2_n_out(cs2), .rs_out(rs), .rd_e_out(rde), .wr_rw_out(wrw),
        .sclk_out(sclk), .sdata_out(sd), .bus_out(bus));

    lhi_host_if lhi_host_if_inst (.core_clk_in(clk), .sys_rst_in(rst),
        .serial_clk_in(sclk), .serial_data_in(sd),
        .interface_kind_select_in(kind), .cpu_family_select_in(fam),
        .cs1_n_in(cs1), .cs2_n_in(cs2), .register_select_in(rs),
        .rd_e_in(rde), .wr_rw_in(wrw), .data_in(bus), .data_out(dout),
        .data_oe_n_out(oen), .pixel_word_out(pix), .pixel_valid_out(pv),
        .dot1_out(d1), .dot2_out(d2), .dot3_out(d3), .burst_out(bst),
        .burst_valid_out(bv), .index_out(idx_o), .cmd_data_out(cd),
        .cmd_valid_out(cv), .bus_width_flag_out(bwf_o),
        .high_speed_mode_out(hs_o));

    task automatic check(input logic [63:0] got, exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic end_of_test();
        check(pq.size() + brq.size() + cq.size(), 0, "results missing");
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // reference behaviour of one accepted write
    task automatic mdl(input logic r, input logic [15:0] v);
        logic [15:0] w;
        if (!r) begin
            idx = v[7:0];
            pend = 0;
            if (idx == 12 && dty) begin
                bq.delete();
                dty = 0;
            end
        end else if (idx != 12) begin
            if (idx < 16) regs[idx] = v[7:0];
            if (idx == 5) {bwf, hs} = {31'h0, v[7], 31'h0, v[0]};
            cq.push_back({idx[7:0], v[7:0]});
        end else if ((bwf || sm) && !pend) begin
            hib = v[7:0];
            pend = 1;
        end else begin
            w = (bwf || sm) ? {hib[7:0], v[7:0]} : v;
            pend = 0;
            if (!hs) pq.push_back(w);
            else bq.push_back(w);
            if (bq.size() == 4) begin
                brq.push_back({bq[0], bq[1], bq[2], bq[3]});
                bq.delete();
            end
        end
    endtask

    task automatic wr(input logic r, input logic [15:0] v);
        mdl(r, v);
        host.pwrite(r, v);
    endtask

    task automatic sw(input logic r, input logic [7:0] v);
        mdl(r, {8'h00, v});
        host.swrite(r, v, 8);
    endtask

    // upper lines carry noise in byte mode, they must be ignored
    task automatic wword(input logic [15:0] w);
        if (bwf) begin
            wr(1'b1, {8'($urandom), w[15:8]});
            wr(1'b1, {8'($urandom), w[7:0]});
        end else wr(1'b1, w);
    endtask

    task automatic rd(input string what);
        host.pread(1'b1, d, on, off);
        check({on[7:0], d[7:0]}, {8'h00, (idx == 12) ? 8'h00 : 8'(regs[idx])},
              what);
        check(off, 16'hffff, "bus release");
    endtask

    always @(posedge clk) begin
        if (pv === 1'b1) begin
            if (pq.size() == 0) check(0, 1, "spurious pixel");
            else begin
                pw = pq.pop_front();
                check({d1, d2, d3, pix}, {pw, pw}, "pixel word");
            end
        end
        if (bv === 1'b1) begin
            if (brq.size() == 0) check(0, 1, "spurious burst");
            else check(bst, brq.pop_front(), "burst");
        end
        if (cv === 1'b1) begin
            if (cq.size() == 0) check(0, 1, "spurious command");
            else check({idx_o, cd}, cq.pop_front(), "command");
        end
    end

    initial begin
        #1000000;
        n_errors++;
        end_of_test();
    end

    initial begin
        void'($urandom(43));
        repeat (20) @(posedge clk);
        #5 rst = 1'b0;
        repeat (5) @(posedge clk);
        check(oen, 16'hffff, "idle bus");
        host.set_mode(1'b1, 1'b0);
        host.select(1'b0, 1'b0);
        wr(1'b0, 16'hff20);
        wr(1'b1, 16'h00a5);
        for (int k = 0; k < 4; k++) begin
            i = $urandom_range(15, 0);
            if (i == 5 || i == 12) i = 3;
            wr(1'b0, {8'($urandom), 8'(i)});
            check(idx_o, 8'(i), "index");
            wr(1'b1, 16'($urandom));
            rd("register read");
        end
        wr(1'b0, 16'h000c);
        repeat (2) wword(16'($urandom));
        rd("display register read");
        wr(1'b0, 16'h0005);
        wr(1'b1, 16'h0080);
        check(bwf_o, 1'b1, "width flag");
        wr(1'b0, 16'h000c);
        repeat (2) wword(16'($urandom));
        host.select(1'b0, 1'b1);
        host.pwrite(1'b1, 16'h1234);
        host.pread(1'b1, d, on, off);
        check(on, 16'hffff, "deselected read");
        host.select(1'b0, 1'b0);
        host.set_mode(1'b1, 1'b1);
        wr(1'b0, 16'h0005);
        wr(1'b1, 16'h0081);
        check(hs_o, 1'b1, "fast mode");
        rd("fast mode read");
        wr(1'b0, 16'h000c);
        repeat (6) wword(16'($urandom));
        wr(1'b0, 16'h000c);
        repeat (3) wword(16'($urandom));
        if (bq.size() != 0) dty = 1;
        host.select(1'b1, 1'b1);
        host.select(1'b0, 1'b0);
        wr(1'b0, 16'h000c);
        repeat (4) wword(16'($urandom));
        wr(1'b0, 16'h0005);
        wr(1'b1, 16'h0000);
        host.set_mode(1'b0, 1'b0);
        sm = 1;
        sw(1'b0, 8'h0c);
        host.swrite(1'b1, 8'h5a, 3);
        host.select(1'b1, 1'b1);
        host.select(1'b0, 1'b0);
        repeat (2) begin
            b = 8'($urandom);
            c = 8'($urandom);
            sw(1'b1, b);
            sw(1'b1, c);
        end
        sw(1'b0, 8'h03);
        sw(1'b1, 8'($urandom));
        host.pread(1'b1, d, on, off);
        check(on, 16'hffff, "serial read");
        end_of_test();
    end
endmodule // lhi_host_if_tb
